// ===== core/rsc_consts.vh
`ifndef RSC_CONSTS_VH
`define RSC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets on the APB
// ----------------------------------------------------------------
`define RSC_OFF_CAUSE      12'h000
`define RSC_OFF_LV_CTRL    12'h004
`define RSC_OFF_LV_LEVEL   12'h008
`define RSC_OFF_WDT_EN     12'h00C
`define RSC_OFF_STATUS     12'h010

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSC_BIT_WDT_FLAG   4
`define RSC_BIT_LV_FLAG    0
`define RSC_BIT_ST_HOLD    0
`define RSC_BIT_ST_OPT     1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSC_RST_BYTE       8'h00
`define RSC_WDT_EN_OPT0    8'h1A
`define RSC_WDT_EN_OPT1    8'h9A

// ----------------------------------------------------------------
// Source vector layout and timing
// ----------------------------------------------------------------
`define RSC_SRC_W          6
`define RSC_SRC_PIN        0
`define RSC_SRC_POC        1
`define RSC_SRC_WDT        2
`define RSC_SRC_LV         3
`define RSC_SRC_OSC        4
`define RSC_SRC_OPT        5
`define RSC_INIT_CYC       2'h3

`endif

// ===== core/rsc_sync.v
// ----------------------------------------------------------------
// Two-stage synchroniser, one per bit
// ----------------------------------------------------------------
module rsc_sync #(
   parameter W = 6
) (
   input  wire         pclk,
   input  wire         presetn,
   input  wire [W-1:0] async_in,
   output wire [W-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < W; i = i + 1)
      begin : g_bit
         reg stage1;
         reg stage2;
         // First stage feeds only the second
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end
            else
            begin
               stage1 <= async_in[i];
               stage2 <= stage1;
            end
         end
         assign sync_out[i] = stage2;
      end
   endgenerate

endmodule

// ===== core/rsc_top.v
// Summary of operation
// - During reset, state takes after-reset values; oscillator wait only holds the core; no program counter.
// - Watchdog enable loads 1AH or 9AH on reset, chosen by option byte.
// - Cause and low-voltage registers reset nominally to 00H, then per source.
// - Watchdog flag: pin/power-on clear it, watchdog sets, low-voltage holds.
// - Low-voltage flag: pin/power-on clear it, watchdog holds, low-voltage sets.
// - Low-voltage control and level clear on pin, power-on, watchdog; hold on low-voltage.
// - Software read of cause register clears it to 00H.
`include "rsc_consts.vh"

module rsc_top (
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        pin_reset_req,
   input  wire        power_on_clear_req,
   input  wire        watchdog_unit_req,
   input  wire        low_voltage_detector_req,
   input  wire        osc_wait,
   input  wire        option_wdt_sel,
   output reg         core_hold,
   output reg  [7:0]  watchdog_enable_register,
   output reg  [7:0]  lowvolt_detect_control,
   output reg  [7:0]  lowvolt_level_select
);

   // ----------------------------------------------------------------
   // Source synchronisation
   // ----------------------------------------------------------------
   wire [`RSC_SRC_W-1:0] src_async;
   wire [`RSC_SRC_W-1:0] src;

   assign src_async[`RSC_SRC_PIN] = pin_reset_req;
   assign src_async[`RSC_SRC_POC] = power_on_clear_req;
   assign src_async[`RSC_SRC_WDT] = watchdog_unit_req;
   assign src_async[`RSC_SRC_LV]  = low_voltage_detector_req;
   assign src_async[`RSC_SRC_OSC] = osc_wait;
   assign src_async[`RSC_SRC_OPT] = option_wdt_sel;

   rsc_sync #(
      .W (`RSC_SRC_W)
   ) u_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (src_async),
      .sync_out (src)
   );

   wire pin_rst = src[`RSC_SRC_PIN];
   wire poc_rst = src[`RSC_SRC_POC];
   wire wdt_rst = src[`RSC_SRC_WDT];
   wire lv_rst  = src[`RSC_SRC_LV];
   wire osc_run = src[`RSC_SRC_OSC];
   wire opt_sel = src[`RSC_SRC_OPT];

   // Pin and power-on share the full clear
   wire hard_clr = pin_rst | poc_rst;
   wire any_rst  = hard_clr | wdt_rst | lv_rst;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   function rsc_hit;
      input [11:0] addr;
      input [11:0] off;
      begin
         rsc_hit = (addr[11:2] == off[11:2]);
      end
   endfunction

   wire xfer_done = psel & penable & pready;
   wire wr_done   = xfer_done & pwrite;
   wire rd_done   = xfer_done & ~pwrite;
   wire mapped    = rsc_hit(paddr, `RSC_OFF_CAUSE) | rsc_hit(paddr, `RSC_OFF_LV_CTRL) |
                    rsc_hit(paddr, `RSC_OFF_LV_LEVEL) | rsc_hit(paddr, `RSC_OFF_WDT_EN) |
                    rsc_hit(paddr, `RSC_OFF_STATUS);
   // Writes are dropped while the core is held so values stay as reset left them
   wire wr_ok     = wr_done & ~core_hold & ~any_rst;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   reg       watchdog_cause_flag;
   reg       lowvolt_cause_flag;
   reg [1:0] init_cnt;

   reg       next_watchdog_cause_flag;
   reg       next_lowvolt_cause_flag;
   reg [7:0] next_lv_ctrl;
   reg [7:0] next_lv_level;
   reg [7:0] next_wdt_en;
   reg [1:0] next_init_cnt;

   wire [7:0] cause_byte = {3'h0, watchdog_cause_flag, 3'h0, lowvolt_cause_flag};
   wire [7:0] opt_value  = opt_sel ? `RSC_WDT_EN_OPT1 : `RSC_WDT_EN_OPT0;

   // Cause flags; hardware events win over the read clear
   always @*
   begin
      next_watchdog_cause_flag = watchdog_cause_flag;
      next_lowvolt_cause_flag  = lowvolt_cause_flag;
      if (hard_clr)
      begin
         next_watchdog_cause_flag = 1'b0;
         next_lowvolt_cause_flag  = 1'b0;
      end
      else if (wdt_rst | lv_rst)
      begin
         if (wdt_rst)
            next_watchdog_cause_flag = 1'b1;
         if (lv_rst)
            next_lowvolt_cause_flag = 1'b1;
      end
      else if (rd_done && rsc_hit(paddr, `RSC_OFF_CAUSE))
      begin
         next_watchdog_cause_flag = 1'b0;
         next_lowvolt_cause_flag  = 1'b0;
      end
   end

   // Low-voltage registers survive only their own reset
   always @*
   begin
      next_lv_ctrl  = lowvolt_detect_control;
      next_lv_level = lowvolt_level_select;
      if (hard_clr | wdt_rst)
      begin
         next_lv_ctrl  = `RSC_RST_BYTE;
         next_lv_level = `RSC_RST_BYTE;
      end
      else if (lv_rst)
      begin
         next_lv_ctrl  = lowvolt_detect_control;
         next_lv_level = lowvolt_level_select;
      end
      else if (wr_ok && rsc_hit(paddr, `RSC_OFF_LV_CTRL))
         next_lv_ctrl = pwdata[7:0];
      else if (wr_ok && rsc_hit(paddr, `RSC_OFF_LV_LEVEL))
         next_lv_level = pwdata[7:0];
   end

   // Watchdog enable follows the option byte after any reset.
   // The init window covers the synchroniser delay after bus reset.
   always @*
   begin
      next_init_cnt = init_cnt;
      next_wdt_en   = watchdog_enable_register;
      if (init_cnt != 2'h0)
         next_init_cnt = init_cnt - 2'h1;
      if (any_rst || init_cnt != 2'h0)
         next_wdt_en = opt_value;
      else if (wr_ok && rsc_hit(paddr, `RSC_OFF_WDT_EN))
         next_wdt_en = pwdata[7:0];
   end

   // Register update; bus reset acts as a power-on clear
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         watchdog_cause_flag      <= 1'b0;
         lowvolt_cause_flag       <= 1'b0;
         lowvolt_detect_control   <= `RSC_RST_BYTE;
         lowvolt_level_select     <= `RSC_RST_BYTE;
         watchdog_enable_register <= `RSC_WDT_EN_OPT0;
         init_cnt                 <= `RSC_INIT_CYC;
         core_hold                <= 1'b1;
      end
      else
      begin
         watchdog_cause_flag      <= next_watchdog_cause_flag;
         lowvolt_cause_flag       <= next_lowvolt_cause_flag;
         lowvolt_detect_control   <= next_lv_ctrl;
         lowvolt_level_select     <= next_lv_level;
         watchdog_enable_register <= next_wdt_en;
         init_cnt                 <= next_init_cnt;
         // Core held while any reset or the oscillator wait runs
         core_hold                <= any_rst | osc_run | (init_cnt != 2'h0);
      end
   end

   // ----------------------------------------------------------------
   // APB answer
   // ----------------------------------------------------------------
   reg [31:0] rd_mux;

   // Read data chosen a cycle early so outputs come from flops
   always @*
   begin
      rd_mux = 32'h0000_0000;
      if (rsc_hit(paddr, `RSC_OFF_CAUSE))
         rd_mux = {24'h00_0000, cause_byte};
      else if (rsc_hit(paddr, `RSC_OFF_LV_CTRL))
         rd_mux = {24'h00_0000, lowvolt_detect_control};
      else if (rsc_hit(paddr, `RSC_OFF_LV_LEVEL))
         rd_mux = {24'h00_0000, lowvolt_level_select};
      else if (rsc_hit(paddr, `RSC_OFF_WDT_EN))
         rd_mux = {24'h00_0000, watchdog_enable_register};
      else if (rsc_hit(paddr, `RSC_OFF_STATUS))
         rd_mux = {30'h0000_0000, opt_sel, core_hold};
   end

   // One wait state on every access
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~mapped;
         // Unmapped writes answer zero data too, so an error never shows stale data
         if (psel & penable & ~pready & (~pwrite | ~mapped))
            prdata <= rd_mux;
      end
   end

endmodule

// ===== bench/rsc_top_assertions.sv
`include "rsc_consts.vh"

// Watches bus answers, hold and source effects at the top ports
module rsc_top_chk (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        pin_reset_req,
   input logic        osc_wait,
   input logic        option_wdt_sel,
   input logic        core_hold,
   input logic [7:0]  watchdog_enable_register,
   input logic [7:0]  lowvolt_detect_control,
   input logic [7:0]  lowvolt_level_select
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ---
   // Properties
   // ---
   chk_one_wait: assert property (psel && penable && !pready |=> pready)
      else $error("no answer after one wait");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready too long");
   chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");
   chk_unmapped_err: assert property (pready && paddr[11:2] > 10'h004 |-> pslverr)
      else $error("unmapped not refused");
   chk_wr_lands: assert property (pready && pwrite && !core_hold && paddr[11:2] == 10'h001
      |=> lowvolt_detect_control == $past(pwdata[7:0])) else $error("write lost");
   chk_hold_wait:
      assert property (osc_wait [*5] |-> core_hold) else $error("wait without hold");
   chk_wdt_opt:
      assert property ($fell(core_hold) |-> watchdog_enable_register == (option_wdt_sel ?
      `RSC_WDT_EN_OPT1 : `RSC_WDT_EN_OPT0)) else $error("bad watchdog enable");
   chk_pin_clear:
      assert property (pin_reset_req [*4] |-> lowvolt_detect_control == 8'h00 &&
      lowvolt_level_select == 8'h00) else $error("lv regs kept on pin");
   cover property (pready && pwrite && !core_hold);
   cover property (pslverr);
   cover property ($fell(core_hold));
endmodule

bind rsc_top rsc_top_chk rsc_top_chk_inst (.*);

// ===== bench/test_rsc_top.sv
`include "rsc_consts.vh"

module test_rsc_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pin_reset_req = 1'b0, power_on_clear_req = 1'b0, watchdog_unit_req = 1'b0;
   logic        low_voltage_detector_req = 1'b0, osc_wait = 1'b0, option_wdt_sel = 1'b0;
   logic        pready, pslverr, core_hold, perr;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rdv, seed = 32'h0000CB31;
   logic [7:0]  watchdog_enable_register, lowvolt_detect_control, lowvolt_level_select;
   logic [7:0]  e_cause = '0, e_ctl = '0, e_lvl = '0;
   logic [3:0]  tbl [6] = '{4'h4, 4'h8, 4'h1, 4'hC, 4'h2, 4'h5};
   int          n_fail = 0, checks = 0, i;

   rsc_top rsc_top_inst (.*);

   // 100 MHz clock
   initial forever #5 pclk = ~pclk;

   // ---
   // Helpers
   // ---
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Pin or power-on wins over setting any flag
   function logic [7:0] cause_exp(logic [3:0] s, logic [7:0] c);
      return (s[1:0] != 2'h0) ? 8'h00 : c | {3'h0, s[2], 3'h0, s[3]};
   endfunction
   task print_verdict;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task cmp(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
   endtask
   task tmo;
      n_fail++;
      $display("CHECK FAILED %0t wait timed out", $time);
      print_verdict();
   endtask
   // One APB transfer; request held until pready is sampled
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20 && pready !== 1'b1; k++)
         @(posedge pclk);
      if (k == 20)
         tmo();
      rdv = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      cmp(rdv, e);
   endtask
   task idle;
      int k;
      for (k = 0; k < 50 && core_hold !== 1'b0; k++)
         @(posedge pclk);
      if (k == 50)
         tmo();
   endtask
   // Source burst long enough to pass the synchroniser
   task pulse(input logic [3:0] s);
      {low_voltage_detector_req, watchdog_unit_req, power_on_clear_req, pin_reset_req} <= s;
      repeat (4) @(posedge pclk);
      {low_voltage_detector_req, watchdog_unit_req, power_on_clear_req, pin_reset_req} <= 4'h0;
      @(posedge pclk);
      idle();
      e_cause = cause_exp(s, e_cause);
      e_ctl = (s[2:0] != 3'h0) ? 8'h00 : e_ctl;
      e_lvl = (s[2:0] != 3'h0) ? 8'h00 : e_lvl;
   endtask
   task chk_all;
      rd(`RSC_OFF_CAUSE, {24'h0, e_cause});
      e_cause = 8'h00;
      rd(`RSC_OFF_CAUSE, 32'h0);
      rd(`RSC_OFF_LV_CTRL, {24'h0, e_ctl});
      rd(`RSC_OFF_LV_LEVEL, {24'h0, e_lvl});
      rd(`RSC_OFF_WDT_EN, option_wdt_sel ? 32'h9A : 32'h1A);
   endtask

   // Main sequence: reset, random source pairs, wait hold, option reset
   initial
   begin
      repeat (3) @(posedge pclk);
      cmp({core_hold, watchdog_enable_register}, 9'h11A);
      cmp({lowvolt_detect_control, lowvolt_level_select}, 16'h0000);
      presetn <= 1'b1;
      idle();
      chk_all();
      for (i = 0; i < 12; i++)
      begin
         apb(1'b1, `RSC_OFF_LV_CTRL, rnd());
         e_ctl = seed[7:0];
         apb(1'b1, `RSC_OFF_LV_LEVEL, rnd());
         e_lvl = seed[7:0];
         apb(1'b1, `RSC_OFF_WDT_EN, rnd());
         rd(`RSC_OFF_WDT_EN, {24'h0, seed[7:0]});
         apb(1'b1, `RSC_OFF_CAUSE, 32'hFFFFFFFF);
         pulse(tbl[i < 6 ? i : rnd() % 6]);
         pulse(tbl[rnd() % 6]);
         chk_all();
      end
      rd(12'h020, 32'h0);
      cmp(perr, 1'b1);
      apb(1'b1, 12'h024, 32'h0000005A);
      cmp(perr, 1'b1);
      cmp(rdv, 32'h0);
      rd(`RSC_OFF_STATUS, 32'h0);
      osc_wait <= 1'b1;
      repeat (6) @(posedge pclk);
      cmp(core_hold, 1'b1);
      apb(1'b1, `RSC_OFF_LV_CTRL, 32'h000000A5);
      osc_wait <= 1'b0;
      idle();
      chk_all();
      option_wdt_sel <= 1'b1;
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      {e_ctl, e_lvl} = 16'h0000;
      idle();
      chk_all();
      rd(`RSC_OFF_STATUS, 32'h2);
      pulse(4'h4);
      chk_all();
      print_verdict();
   end
endmodule
